/* File: rtl/ied_pkg.sv */
// Purpose: shared constants and types for interrupt and exception dispatch
// Assumes: 32-bit program addresses, one core clock
// Notes:   offsets, the enable flag position and multi-bit reset values live here
package ied_pkg;

    localparam int          VEC_W          = 8;
    localparam int          NUM_VEC        = 256;
    localparam logic [7:0]  RSVD_VEC       = 8'h20;
    localparam logic [7:0]  NMI_VEC        = 8'h02;
    localparam logic [31:0] REAL_ENT_BYTES = 32'h0000_0004;
    localparam logic [31:0] PROT_ENT_BYTES = 32'h0000_0008;
    localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;
    localparam int          IF_BIT         = 9;
    localparam logic [31:0] FLAGS_RST      = 32'h0000_0002;
    localparam logic [31:0] ADDR_RST       = 32'h0000_0000;
    localparam logic [15:0] SEL_RST        = 16'h0000;
    localparam logic [7:0]  VEC_RST        = 8'h00;

    // event classes
    typedef enum logic [2:0] {
        CLS_MASKABLE_REQUEST_INPUT  = 3'h0,
        CLS_NMI   = 3'h1,
        CLS_FAULT = 3'h2,
        CLS_TRAP  = 3'h3,
        CLS_ABORT = 3'h4
    } ied_cls_e;

    // gray along push, ack, table; return path on the far half
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_PUSH_IP = 3'h1,
        ST_PUSH_FL = 3'h3,
        ST_ACK     = 3'h2,
        ST_TBL     = 3'h6,
        ST_POP_FL  = 3'h5,
        ST_POP_IP  = 3'h4
    } ied_state_e;

    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_PUSH = 2'h1,
        OP_POP  = 2'h2,
        OP_TBL  = 2'h3
    } ied_op_e;

    typedef struct packed {
        logic        take;
        logic        ack;
        ied_cls_e    cls;
        logic [7:0]  vec;
        logic [31:0] ret_ip;
    } ied_evt_s;

endpackage

/* File: rtl/ied_classify.sv */
// Purpose: pick the winning event and its return point
// Assumes: fault and abort arrive before the instruction completes
// Notes:   purely combinational
`timescale 1ns/1ns
`default_nettype none
module ied_classify
(
    // core events
    input  wire logic             insn_done,
    input  wire logic             exc_req,
    input  wire ied_pkg::ied_cls_e exc_cls,
    input  wire logic [7:0]       exc_vec,
    input  wire logic             sw_req,
    input  wire logic [7:0]       sw_vec,
    input  wire logic [31:0]      insn_ip,
    input  wire logic [31:0]      next_ip,
    // hardware requests already qualified
    input  wire logic             nmi_ok,
    input  wire logic             maskable_request_input_ok,
    // result
    output var  ied_pkg::ied_evt_s evt
);
    wire logic     hw_ok    = insn_done & ~exc_req & ~sw_req;
    wire logic     take_nmi = hw_ok & nmi_ok;
    wire logic     take_int = hw_ok & ~nmi_ok & maskable_request_input_ok;
    wire ied_pkg::ied_cls_e cls =
        exc_req  ? exc_cls :
        sw_req   ? ied_pkg::CLS_TRAP :
        take_nmi ? ied_pkg::CLS_NMI : ied_pkg::CLS_MASKABLE_REQUEST_INPUT;
    // restartable classes return to the instruction start, prefixes included
    wire logic     restart  = exc_req & (exc_cls == ied_pkg::CLS_FAULT ||
                                         exc_cls == ied_pkg::CLS_ABORT);

    always_comb
    begin
        evt.take   = exc_req | sw_req | take_nmi | take_int;
        evt.cls    = cls;
        evt.ack    = take_int & ~exc_req & ~sw_req;
        evt.vec    = exc_req ? exc_vec : sw_req ? sw_vec :
                     take_nmi ? ied_pkg::NMI_VEC : ied_pkg::VEC_RST;
        evt.ret_ip = restart ? insn_ip : next_ip;
    end
endmodule // ied_classify
`default_nettype wire

/* File: rtl/ied_entry_addr.sv */
// Purpose: byte address of one word of a vector table entry
// Assumes: table base is byte aligned to the entry size by software
// Notes:   entry size follows the mode latched at the event
`timescale 1ns/1ns
`default_nettype none
module ied_entry_addr
(
    // entry selection
    input  wire logic [31:0] base,
    input  wire logic [7:0]  vec,
    input  wire logic        prot,
    input  wire logic        word,
    // result
    output var  logic [31:0] addr
);
    localparam logic [31:0] ADDR0 = ied_pkg::ADDR_RST;

    wire logic [31:0] ent_sz = prot ? ied_pkg::PROT_ENT_BYTES
                                    : ied_pkg::REAL_ENT_BYTES;
    wire logic [31:0] prod   = {24'h000000, vec} * ent_sz;
    wire logic [31:0] woff   = word ? ied_pkg::WORD_BYTES : ADDR0;

    always_comb
    begin
        addr = base + prod + woff;
    end
endmodule // ied_entry_addr
`default_nettype wire

/* File: rtl/ied_dispatch.sv */
// Purpose: interrupt and exception dispatch sequencer
// Assumes: core stalls while busy_r; stack unit does its own addressing
// Notes:   one event is dispatched at a time
//
// Overview of operation
// - hardware interrupts are taken only at an instruction boundary, return after it
// - faults are taken before completion; return points at the instruction start
// - traps are taken after the instruction; return points at the next one
// - aborts report severe errors where the causing instruction is unknown
// - up to 256 vectors, each selecting one table entry
// - real mode entries are 4 bytes: segment and 16-bit offset
// - protected mode entries are 8 byte descriptors
// - vectors below 32 belong to the device; external ones should be above
// - push address then flags, then get vector, read table, start handler
// - return from handler restores saved state and resumes
// - exceptions supply vectors internally; software calls take it from the instruction
// - maskable interrupts run an acknowledge cycle returning the vector
// - non-maskable request dispatches to vector 2 with no acknowledge
// - software vector calls are handled as exceptions
// - maskable interrupt needs request high and enable flag set
// - enable flag cleared on handler entry, restored by return
// - non-maskable requests held off during its handler; one is remembered
// - non-maskable wins over maskable at the same boundary
`timescale 1ns/1ns
`default_nettype none
module ied_dispatch
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_b,
    // core events
    input  wire logic              insn_done,
    input  wire logic [31:0]       insn_ip,
    input  wire logic [31:0]       next_ip,
    input  wire logic              exc_req,
    input  wire ied_pkg::ied_cls_e exc_cls,
    input  wire logic [7:0]        exc_vec,
    input  wire logic              sw_req,
    input  wire logic [7:0]        sw_vec,
    input  wire logic              ret_req,
    input  wire logic              prot_mode,
    input  wire logic [31:0]       tbl_base,
    input  wire logic              flags_wr,
    input  wire logic [31:0]       flags_in,
    // request pins
    input  wire logic              maskable_request_input,
    input  wire logic              nmi_req,
    // acknowledge cycle to the controller
    output var  logic              inta_r,
    input  wire logic              inta_vec_valid,
    input  wire logic [7:0]        inta_vec,
    // memory port for stack and table
    output var  logic              bus_req_r,
    output var  ied_pkg::ied_op_e  bus_op_r,
    output var  logic [31:0]       bus_addr_r,
    output var  logic [31:0]       bus_wdata_r,
    input  wire logic              bus_ack,
    input  wire logic [31:0]       bus_rdata,
    // status and handoff to the core
    output var  logic              busy_r,
    output var  ied_pkg::ied_cls_e evt_cls_r,
    output var  logic [7:0]        evt_vec_r,
    output var  logic              vec_rsvd_r,
    output var  logic [31:0]       flags_r,
    output var  logic              handler_go_r,
    output var  logic [15:0]       handler_cs_r,
    output var  logic [31:0]       handler_ip_r,
    output var  logic              resume_go_r,
    output var  logic [31:0]       resume_ip_r
);

////////////////////////////////////////////////////////////////////////////////

    ied_pkg::ied_state_e state_r;
    ied_pkg::ied_state_e state_nxt;
    ied_pkg::ied_evt_s   evt;
    logic [31:0]         ret_ip_r;
    logic [31:0]         flags_sv_r;
    logic                need_ack_r;
    logic                prot_r;
    logic                word_r;
    logic                nmi_d_r;
    logic                nmi_pend_r;
    logic                nmi_busy_r;
    logic [31:0]         ent_addr;

    wire logic st_idle   = (state_r == ied_pkg::ST_IDLE);
    wire logic st_ack    = (state_r == ied_pkg::ST_ACK);
    wire logic st_tbl    = (state_r == ied_pkg::ST_TBL);
    wire logic st_puship = (state_r == ied_pkg::ST_PUSH_IP);
    wire logic st_popip  = (state_r == ied_pkg::ST_POP_IP);
    wire logic st_popfl  = (state_r == ied_pkg::ST_POP_FL);

    // requests are only taken while idle (nmi edges latch in any state); the core stalls otherwise
    wire logic ret_now   = st_idle & ret_req;
    wire logic take_now  = st_idle & ~ret_req & evt.take;
    wire logic take_nmi  = take_now & (evt.cls == ied_pkg::CLS_NMI);
    wire logic maskable_request_input_ok   = maskable_request_input & flags_r[ied_pkg::IF_BIT];
    wire logic nmi_ok    = nmi_pend_r & ~nmi_busy_r;
    wire logic nmi_edge  = nmi_req & ~nmi_d_r;
    wire logic vec_in    = st_ack & inta_vec_valid;
    wire logic tbl_last  = st_tbl & bus_ack & (word_r | ~prot_r);
    wire logic ret_done  = st_popfl & bus_ack;

    wire logic [7:0] vec_nxt   = take_now ? evt.vec : vec_in ? inta_vec : evt_vec_r;
    wire logic       prot_nxt  = take_now ? prot_mode : prot_r;
    wire logic       word_nxt  = (state_nxt == ied_pkg::ST_TBL) & (word_r | (st_tbl & bus_ack));
    wire logic       bus_nxt   = (state_nxt != ied_pkg::ST_IDLE) &
                                 (state_nxt != ied_pkg::ST_ACK);
    wire ied_pkg::ied_op_e op_nxt =
        (state_nxt == ied_pkg::ST_TBL) ? ied_pkg::OP_TBL :
        (state_nxt == ied_pkg::ST_POP_IP || state_nxt == ied_pkg::ST_POP_FL) ?
        ied_pkg::OP_POP : bus_nxt ? ied_pkg::OP_PUSH : ied_pkg::OP_NONE;
    // program address goes out first, saved flags on its acknowledge
    wire logic [31:0] wdata_nxt = take_now ? evt.ret_ip :
                                  (st_puship & bus_ack) ? flags_sv_r : bus_wdata_r;
    wire logic [31:0] addr_nxt  = (state_nxt == ied_pkg::ST_TBL) ? ent_addr
                                                                 : ied_pkg::ADDR_RST;

////////////////////////////////////////////////////////////////////////////////

    ied_classify u_classify
    (
        .insn_done (insn_done),
        .exc_req   (exc_req),
        .exc_cls   (exc_cls),
        .exc_vec   (exc_vec),
        .sw_req    (sw_req),
        .sw_vec    (sw_vec),
        .insn_ip   (insn_ip),
        .next_ip   (next_ip),
        .nmi_ok    (nmi_ok),
        .maskable_request_input_ok   (maskable_request_input_ok),
        .evt       (evt)
    );

    ied_entry_addr u_entry
    (
        .base (tbl_base),
        .vec  (vec_nxt),
        .prot (prot_nxt),
        .word (word_nxt),
        .addr (ent_addr)
    );

////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ied_pkg::ST_IDLE:
                if (ret_now)
                    state_nxt = ied_pkg::ST_POP_IP;
                else if (take_now)
                    state_nxt = ied_pkg::ST_PUSH_IP;
            ied_pkg::ST_PUSH_IP:
                if (bus_ack)
                    state_nxt = ied_pkg::ST_PUSH_FL;
            ied_pkg::ST_PUSH_FL:
                if (bus_ack)
                    state_nxt = need_ack_r ? ied_pkg::ST_ACK : ied_pkg::ST_TBL;
            ied_pkg::ST_ACK:
                if (inta_vec_valid)
                    state_nxt = ied_pkg::ST_TBL;
            ied_pkg::ST_TBL:
                if (tbl_last)
                    state_nxt = ied_pkg::ST_IDLE;
            ied_pkg::ST_POP_IP:
                if (bus_ack)
                    state_nxt = ied_pkg::ST_POP_FL;
            ied_pkg::ST_POP_FL:
                if (bus_ack)
                    state_nxt = ied_pkg::ST_IDLE;
            default:
                state_nxt = ied_pkg::ST_IDLE;
        endcase
    end

////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state_r     <= ied_pkg::ST_IDLE;
            bus_req_r   <= 1'b0;
            bus_op_r    <= ied_pkg::OP_NONE;
            bus_addr_r  <= ied_pkg::ADDR_RST;
            bus_wdata_r <= ied_pkg::ADDR_RST;
            inta_r      <= 1'b0;
            busy_r      <= 1'b0;
            evt_vec_r   <= ied_pkg::VEC_RST;
            prot_r      <= 1'b0;
            word_r      <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            bus_req_r   <= bus_nxt;
            bus_op_r    <= op_nxt;
            bus_addr_r  <= addr_nxt;
            bus_wdata_r <= wdata_nxt;
            inta_r      <= (state_nxt == ied_pkg::ST_ACK);
            busy_r      <= (state_nxt != ied_pkg::ST_IDLE);
            evt_vec_r   <= vec_nxt;
            prot_r      <= prot_nxt;
            word_r      <= word_nxt;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            evt_cls_r  <= ied_pkg::CLS_MASKABLE_REQUEST_INPUT;
            ret_ip_r   <= ied_pkg::ADDR_RST;
            flags_sv_r <= ied_pkg::FLAGS_RST;
            need_ack_r <= 1'b0;
            vec_rsvd_r <= 1'b0;
        end
        else if (take_now)
        begin
            evt_cls_r  <= evt.cls;
            ret_ip_r   <= evt.ret_ip;
            flags_sv_r <= flags_r;
            need_ack_r <= evt.ack;
            vec_rsvd_r <= 1'b0;
        end
        else if (vec_in)
        begin
            // reserved vectors from outside are flagged, still dispatched
            vec_rsvd_r <= (inta_vec < ied_pkg::RSVD_VEC);
        end
    end

    // entry clears the enable flag; return restores the stacked copy
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            flags_r <= ied_pkg::FLAGS_RST;
        else if (take_now)
            flags_r <= flags_r & ~(32'h0000_0001 << ied_pkg::IF_BIT);
        else if (ret_done)
            flags_r <= bus_rdata;
        else if (flags_wr)
            flags_r <= flags_in;
    end

    // one remembered request; a new edge beats the clear on take
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            nmi_d_r    <= 1'b0;
            nmi_pend_r <= 1'b0;
            nmi_busy_r <= 1'b0;
        end
        else
        begin
            nmi_d_r    <= nmi_req;
            nmi_pend_r <= nmi_edge | (nmi_pend_r & ~take_nmi);
            nmi_busy_r <= take_nmi | (nmi_busy_r & ~ret_done);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            handler_go_r <= 1'b0;
            handler_cs_r <= ied_pkg::SEL_RST;
            handler_ip_r <= ied_pkg::ADDR_RST;
            resume_go_r  <= 1'b0;
            resume_ip_r  <= ied_pkg::ADDR_RST;
        end
        else
        begin
            handler_go_r <= tbl_last;
            resume_go_r  <= ret_done;
            if (st_tbl & bus_ack & ~word_r)
            begin
                handler_cs_r <= bus_rdata[31:16];
                handler_ip_r <= {16'h0000, bus_rdata[15:0]};
            end
            else if (st_tbl & bus_ack)
                handler_ip_r <= {bus_rdata[31:16], handler_ip_r[15:0]};
            if (st_popip & bus_ack)
                resume_ip_r <= bus_rdata;
        end
    end

////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_take_hw;
        take_now && (evt.cls == ied_pkg::CLS_MASKABLE_REQUEST_INPUT || evt.cls == ied_pkg::CLS_NMI);
    endsequence
    sequence s_push_ip;
        bus_req_r && bus_op_r == ied_pkg::OP_PUSH && state_r == ied_pkg::ST_PUSH_IP;
    endsequence

    AST_HW_AT_BOUNDARY: assert property (s_take_hw |-> insn_done && !exc_req)
        else $error("hardware interrupt taken off a boundary");
    AST_FAULT_RET: assert property (take_now && exc_req && exc_cls == ied_pkg::CLS_FAULT
        |=> ret_ip_r == $past(insn_ip))
        else $error("fault return point is not the instruction start");
    AST_TRAP_RET: assert property (take_now && evt.cls == ied_pkg::CLS_TRAP
        |=> ret_ip_r == $past(next_ip))
        else $error("trap return point is not the next instruction");
    AST_PUSH_ORDER: assert property (take_now |=> s_push_ip ##0 bus_wdata_r == ret_ip_r)
        else $error("address is not the first push");
    AST_NMI_VEC: assert property (take_nmi |=> evt_vec_r == ied_pkg::NMI_VEC
        ##1 !inta_r [*2])
        else $error("non-maskable dispatch wrong vector or acknowledged");
    AST_IF_CLEAR: assert property (take_now |=> !flags_r[ied_pkg::IF_BIT])
        else $error("enable flag not cleared on entry");
    AST_NMI_FIRST: assert property (take_now && nmi_ok && maskable_request_input_ok && insn_done
        && !exc_req && !sw_req |-> evt.cls == ied_pkg::CLS_NMI)
        else $error("maskable beat non-maskable");
    AST_NMI_HOLD: assert property (nmi_busy_r |-> !take_nmi)
        else $error("non-maskable nested");
    AST_NMI_KEEP: assert property (nmi_busy_r && nmi_edge |=> nmi_pend_r)
        else $error("non-maskable request during handler lost");
    AST_INTA_VEC: assert property (vec_in |=> evt_vec_r == $past(inta_vec)
        && state_r == ied_pkg::ST_TBL && !inta_r)
        else $error("acknowledged vector not used");
    AST_ENTRY_ADDR: assert property ($rose(state_r == ied_pkg::ST_TBL) |->
        bus_addr_r == tbl_base + {24'h000000, evt_vec_r} *
        (prot_r ? ied_pkg::PROT_ENT_BYTES : ied_pkg::REAL_ENT_BYTES))
        else $error("table entry address wrong");
    AST_RET_FLAGS: assert property (ret_done |=> flags_r == $past(bus_rdata)
        && resume_go_r && !nmi_busy_r)
        else $error("return did not restore state");

endmodule // ied_dispatch
`default_nettype wire

/* File: test/ied_pic_model.sv */
// Purpose: interrupt controller model answering acknowledge cycles
// Assumes: one request in flight at a time
// Notes:   slow mode answers three cycles late
`timescale 1ns/1ns
`default_nettype none
module ied_pic_model
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // bench control
    input  wire logic       raise,
    input  wire logic [7:0] vec_in,
    input  wire logic       slow,
    // device side
    output var  logic       maskable_request_input,
    input  wire logic       inta_r,
    output var  logic       inta_vec_valid,
    output var  logic [7:0] inta_vec
);
    logic [1:0] wait_r;
    logic       done_r;
    logic [7:0] vec_r;
    ////////////////////////////////////////////////////////////
    always_ff @(posedge mclk)
    begin
        inta_vec_valid <= 1'b0;
        inta_vec       <= ~inta_vec; // released lines never hold a value
        if (!rst_b)
        begin
            maskable_request_input <= 1'b0;
            done_r                 <= 1'b0;
            wait_r                 <= 2'h0;
            inta_vec               <= 8'h00;
        end
        else
        begin
            if (raise)
            begin
                maskable_request_input <= 1'b1;
                vec_r                  <= vec_in;
                wait_r                 <= slow ? 2'h3 : 2'h0;
            end
            if (!inta_r)
                done_r <= 1'b0;
            else if (!done_r && wait_r != 2'h0)
                wait_r <= wait_r - 2'h1;
            else if (!done_r)
            begin
                inta_vec_valid         <= 1'b1;
                inta_vec               <= vec_r;
                done_r                 <= 1'b1;
                maskable_request_input <= 1'b0; // held until acknowledged
            end
        end
    end
endmodule // ied_pic_model
`default_nettype wire

/* File: test/ied_dispatch_tb_top.sv */
// Purpose: self-checking bench for the dispatch sequencer
// Assumes: bench plays core, stack unit and table memory
// Notes:   stack model pops return ip first, then flags
`timescale 1ns/1ns
`default_nettype none
module ied_dispatch_tb_top;
    logic mclk, rst_b, insn_done, exc_req, sw_req, ret_req, prot_mode, flags_wr, nmi_req;
    logic [31:0] insn_ip, next_ip, tbl_base, flags_in, bus_rdata, bus_wdata_r, bus_addr_r;
    logic [31:0] handler_ip_r, resume_ip_r, flags_r, efl, lfsr_r;
    logic [15:0] handler_cs_r;
    logic [7:0] exc_vec, sw_vec, inta_vec, pic_vec, evt_vec_r;
    logic maskable_request_input, inta_r, inta_vec_valid, bus_ack, bus_req_r, busy_r;
    logic vec_rsvd_r, handler_go_r, resume_go_r, pic_raise, slow, saw_ack, tog;
    ied_pkg::ied_cls_e exc_cls, evt_cls_r;
    ied_pkg::ied_op_e bus_op_r;
    logic [31:0] stk[$];
    int num_errors, n_checks, pc;
    ied_dispatch ied_dispatch_i (.mclk(mclk), .rst_b(rst_b), .insn_done(insn_done),
        .insn_ip(insn_ip), .next_ip(next_ip), .exc_req(exc_req), .exc_cls(exc_cls),
        .exc_vec(exc_vec), .sw_req(sw_req), .sw_vec(sw_vec), .ret_req(ret_req),
        .prot_mode(prot_mode), .tbl_base(tbl_base), .flags_wr(flags_wr), .flags_in(flags_in),
        .maskable_request_input(maskable_request_input), .nmi_req(nmi_req), .inta_r(inta_r),
        .inta_vec_valid(inta_vec_valid), .inta_vec(inta_vec), .bus_req_r(bus_req_r),
        .bus_op_r(bus_op_r), .bus_addr_r(bus_addr_r), .bus_wdata_r(bus_wdata_r),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata), .busy_r(busy_r), .evt_cls_r(evt_cls_r),
        .evt_vec_r(evt_vec_r), .vec_rsvd_r(vec_rsvd_r), .flags_r(flags_r),
        .handler_go_r(handler_go_r), .handler_cs_r(handler_cs_r),
        .handler_ip_r(handler_ip_r), .resume_go_r(resume_go_r), .resume_ip_r(resume_ip_r));
    ied_pic_model ied_pic_model_i (.mclk(mclk), .rst_b(rst_b), .raise(pic_raise),
        .vec_in(pic_vec), .slow(slow), .maskable_request_input(maskable_request_input),
        .inta_r(inta_r), .inta_vec_valid(inta_vec_valid), .inta_vec(inta_vec));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    always #5 mclk = ~mclk;
    always @(negedge mclk)
        if (inta_r === 1'b1) saw_ack = 1'b1;
    // stack and table memory, stalls at random
    always @(posedge mclk)
    begin
        bus_ack   <= 1'b0;
        bus_rdata <= ~bus_rdata;
        if (bus_req_r === 1'b1 && !bus_ack && rnd() % 3 != 0)
        begin
            bus_ack <= 1'b1;
            if (bus_op_r == ied_pkg::OP_PUSH) stk.push_back(bus_wdata_r);
            if (bus_op_r == ied_pkg::OP_TBL) bus_rdata <= {~bus_addr_r[15:0], bus_addr_r[15:0]};
            if (bus_op_r == ied_pkg::OP_POP)
            begin
                bus_rdata <= stk[stk.size() - 2 + pc];
                if (pc == 1) stk = stk[0:$-2];
                pc = 1 - pc;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic raise_maskable_request_input(input logic [7:0] v);
        @(posedge mclk);
        pic_raise <= 1'b1;
        pic_vec   <= v;
        slow      <= 1'(rnd());
        @(posedge mclk);
        pic_raise <= 1'b0;
    endtask
    // k: 0 fault 1 trap 2 abort 3 software 4 maskable 5 nmi edge 6 pending nmi
    task automatic fire(input int k, input logic [7:0] v);
        logic [31:0] bs, ii, ni, a0, a1;
        logic [7:0]  ev;
        ied_pkg::ied_cls_e cl;
        int n;
        bs = {4'h0, 16'(rnd()), 12'h000};
        ii = rnd();
        ni = rnd();
        tog = !tog;
        ev = (k > 4) ? ied_pkg::NMI_VEC : v;
        a0 = bs + {24'h0, ev} * (tog ? 32'h8 : 32'h4);
        a1 = a0 + 32'h4;
        cl = (k == 0) ? ied_pkg::CLS_FAULT : (k == 1 || k == 3) ? ied_pkg::CLS_TRAP :
             (k == 2) ? ied_pkg::CLS_ABORT : (k == 4) ? ied_pkg::CLS_MASKABLE_REQUEST_INPUT : ied_pkg::CLS_NMI;
        @(posedge mclk);
        {prot_mode, tbl_base, insn_ip, next_ip} <= {tog, bs, ii, ni};
        {exc_vec, sw_vec} <= {v, v};
        exc_cls <= cl;
        nmi_req <= (k == 5);
        saw_ack = 1'b0;
        @(posedge mclk);
        exc_req   <= (k < 3);
        sw_req    <= (k == 3);
        insn_done <= (k > 2);
        @(posedge mclk);
        {exc_req, sw_req, insn_done, nmi_req} <= 4'h0;
        n = 0;
        do @(negedge mclk); while (handler_go_r !== 1'b1 && ++n < 80);
        chk("handler_go", 1, handler_go_r);
        chk("handler_cs", {16'h0, ~a0[15:0]}, handler_cs_r);
        chk("handler_ip", tog ? {~a1[15:0], a0[15:0]} : {16'h0, a0[15:0]}, handler_ip_r);
        chk("vector", ev, evt_vec_r);
        chk("pushed_ip", (k == 0 || k == 2) ? ii : ni, stk[$-1]);
        chk("pushed_flags", efl, stk[$]);
        chk("enable", 0, flags_r[ied_pkg::IF_BIT]);
        chk("ack_cycle", k == 4, saw_ack);
        chk("class", cl, evt_cls_r);
        if (k == 4) chk("reserved", v < 8'h20, vec_rsvd_r);
        efl[ied_pkg::IF_BIT] = 1'b0;
    endtask
    task automatic ret();
        logic [31:0] e_ip, e_fl;
        int n;
        e_ip = stk[$-1];
        e_fl = stk[$];
        @(posedge mclk);
        ret_req <= 1'b1;
        @(posedge mclk);
        ret_req <= 1'b0;
        n = 0;
        do @(negedge mclk); while (resume_go_r !== 1'b1 && ++n < 80);
        chk("resume_go", 1, resume_go_r);
        chk("resume_ip", e_ip, resume_ip_r);
        chk("flags", e_fl, flags_r);
        efl = e_fl;
    endtask
    // boundary that must not be taken
    task automatic quiet(input logic nm);
        @(posedge mclk);
        insn_done <= 1'b1;
        nmi_req   <= nm;
        @(posedge mclk);
        {insn_done, nmi_req} <= 2'h0;
        repeat (4) @(negedge mclk);
        chk("busy", 0, busy_r);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        {mclk, insn_done, exc_req, sw_req, ret_req, prot_mode, flags_wr, nmi_req} = 8'h00;
        {insn_ip, next_ip, tbl_base, flags_in, bus_rdata} = '0;
        {exc_vec, sw_vec, pic_vec, pic_raise, slow, bus_ack, saw_ack, tog} = '0;
        exc_cls = ied_pkg::CLS_FAULT;
        {rst_b, lfsr_r, efl, pc} = {1'b0, 32'h49a1, 32'h2, 32'h0};
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            fire(i % 4, 8'(rnd()));
            ret();
        end
        @(posedge mclk);
        {flags_wr, flags_in} <= {1'b1, efl | 32'h200};
        efl = efl | 32'h200;
        @(posedge mclk);
        flags_wr <= 1'b0;
        raise_maskable_request_input(8'h05);
        fire(4, 8'h05);
        ret();
        raise_maskable_request_input(8'(32'h20 + rnd() % 224));
        fire(4, pic_vec);
        ret();
        raise_maskable_request_input(8'hff);
        fire(5, 8'h00);
        quiet(1'b1);
        ret();
        fire(6, 8'h00);
        ret();
        fire(4, 8'hff);
        ret();
        tally_and_finish();
    end
endmodule // ied_dispatch_tb_top
`default_nettype wire
